// ### rtl/spimsc_core.sv
/*
  spimsc_core: serial peripheral core, master or slave, full duplex.
  assumes pins are wired by the testbench from the output enables;
  software-side strobes are one-cycle pulses in the clk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module spimsc_core
  import spimsc_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    enable,
  input  wire logic                    masterSelectBit,
  input  wire logic [1:0]              periphSelectField,
  input  wire logic [4*SPIMSC_CFG_W-1:0] selectCfg,
  input  wire logic                    txWrite,
  input  wire logic [SPIMSC_MAX_BITS-1:0] txData,
  input  wire logic                    rxRead,
  input  wire logic                    statusRead,
  output logic [SPIMSC_MAX_BITS-1:0]   rxHoldingReg,
  output logic                         txHoldingEmpty,
  output logic                         transferDoneFlag,
  output logic                         rxHoldingFull,
  output logic                         rxOverrunFlag,
  output logic                         dmaTxRequest,
  output logic                         sclkOut,
  output logic                         sclkOe,
  input  wire logic                    sclkIn,
  output logic                         mosiOut,
  output logic                         mosiOe,
  input  wire logic                    mosiIn,
  output logic                         misoOut,
  output logic                         misoOe,
  input  wire logic                    misoIn,
  output logic [3:0]                   periphSelectN,
  output logic [3:0]                   periphSelectOe,
  input  wire logic                    select0OrSlaveSelectN
);
  typedef enum logic [1:0] {
    SPIMSC_IDLE  = 2'b00,
    SPIMSC_SHIFT = 2'b01,
    SPIMSC_DELAY = 2'b10
  } spimsc_state_t;

  typedef struct packed {
    spimsc_state_t             state;
    logic [SPIMSC_MAX_BITS-1:0] txHold;
    logic [SPIMSC_MAX_BITS-1:0] shift;
    logic [SPIMSC_MAX_BITS-1:0] rxHold;
    logic                      transfer_done_flag;
    logic                      done;
    logic                      rxFull;
    logic                      ovr;
    logic [7:0]                divCnt;
    logic [7:0]                dlyCnt;
    logic [4:0]                bitCnt;
    logic                      half;
    logic                      sclk;
    logic                      mosi;
    logic                      miso;
    logic [3:0]                csN;
    logic [1:0]                curCs;
    logic                      sclkPrev;
    logic                      ssPrev;
  } spimsc_core_t;

  spimsc_core_t st_q;
  spimsc_core_t st_d;

  spimsc_cfg_if cfg ();

  logic sclkS;
  logic mosiS;
  logic misoS;
  logic ssS;

  spimsc_sync #(.W(4)) i_spimsc_sync (
    .clk    (clk),
    .reset  (reset),
    .async  ({sclkIn, mosiIn, misoIn, select0OrSlaveSelectN}),
    .synced ({sclkS, mosiS, misoS, ssS})
  );

  function automatic logic [SPIMSC_CFG_W-1:0] cfgOf(input logic [1:0] idx);
    cfgOf = selectCfg[idx*SPIMSC_CFG_W +: SPIMSC_CFG_W];
  endfunction

  logic [SPIMSC_CFG_W-1:0] act;
  logic [7:0]              div;
  logic [7:0]              dly;
  logic [4:0]              bitsClamped;

  always_comb begin
    // slave looks at select 0 only; master at the select being used
    act = masterSelectBit ? cfgOf(st_q.state == SPIMSC_IDLE ? periphSelectField : st_q.curCs)
                          : cfgOf(2'b00);
    div = act[SPIMSC_CFG_DIV_LO +: 8];
    // zero is forbidden; treat as one so the generator cannot stall
    if (div == 8'h00) begin
      div = SPIMSC_DIV_RESET;
    end
    dly = act[SPIMSC_CFG_DLY_LO +: 8];
    bitsClamped = act[SPIMSC_CFG_BITS_LO +: 5];
    if (bitsClamped < SPIMSC_MIN_BITS) begin
      bitsClamped = SPIMSC_MIN_BITS;
    end else if (bitsClamped > 5'(SPIMSC_MAX_BITS)) begin
      bitsClamped = 5'(SPIMSC_MAX_BITS);
    end
  end

  assign cfg.pol      = act[SPIMSC_CFG_POL];
  assign cfg.phaInv   = act[SPIMSC_CFG_PHA_INV];
  assign cfg.bits     = bitsClamped;
  assign cfg.isMaster = masterSelectBit;

  // msb of the active word length
  function automatic logic msbOf(input logic [SPIMSC_MAX_BITS-1:0] w, input logic [4:0] n);
    msbOf = w[4'(n - 5'h01)];
  endfunction

  function automatic logic [SPIMSC_MAX_BITS-1:0] shl(input logic [SPIMSC_MAX_BITS-1:0] w,
                                                      input logic b);
    shl = {w[SPIMSC_MAX_BITS-2:0], b};
  endfunction

  function automatic logic [SPIMSC_MAX_BITS-1:0] maskTo(input logic [SPIMSC_MAX_BITS-1:0] w,
                                                         input logic [4:0] n);
    maskTo = w & ((SPIMSC_MAX_BITS'(1) << n) - SPIMSC_MAX_BITS'(1));
  endfunction

  logic wordEnd;
  logic sclkEdge;
  logic leadEdge;
  logic ssActive;

  always_comb begin
    st_d     = st_q;
    wordEnd  = 1'b0;
    sclkEdge = 1'b0;
    leadEdge = 1'b0;
    ssActive = ~ssS;
    st_d.sclkPrev = sclkS;
    st_d.ssPrev   = ssS;

    if (txWrite) begin
      st_d.txHold  = txData;
      st_d.transfer_done_flag = 1'b0;
      st_d.done    = 1'b0;
    end

    if (!enable) begin
      st_d.state = SPIMSC_IDLE;
      st_d.csN   = SPIMSC_CS_IDLE;
      st_d.sclk  = cfg.pol;
    end else if (cfg.isMaster) begin
      case (st_q.state)
        SPIMSC_IDLE: begin
          st_d.sclk = cfg.pol;
          st_d.csN  = SPIMSC_CS_IDLE;
          if (!st_q.transfer_done_flag) begin
            // word moves straight into the idle shifter
            st_d.shift   = st_q.txHold;
            st_d.transfer_done_flag = txWrite ? 1'b0 : 1'b1;
            st_d.curCs   = periphSelectField;
            st_d.csN     = ~(4'h1 << periphSelectField);
            st_d.bitCnt  = 5'h00;
            st_d.half    = 1'b0;
            st_d.divCnt  = div;
            st_d.mosi    = msbOf(st_q.txHold, cfg.bits);
            st_d.state   = SPIMSC_SHIFT;
          end
        end
        SPIMSC_SHIFT: begin
          // baud counter only ticks here, never in slave mode
          if (st_q.divCnt > 8'h01) begin
            st_d.divCnt = st_q.divCnt - 8'h01;
          end else begin
            st_d.divCnt = div;
            st_d.sclk   = ~st_q.sclk;
            st_d.half   = ~st_q.half;
            if (st_q.half != cfg.phaInv) begin
              // capture edge: synced pin still shows the pre-edge level,
              // so a divisor of 3 or more is needed for margin
              st_d.shift = shl(st_q.shift, misoS);
            end
            if (st_q.half) begin
              st_d.bitCnt = st_q.bitCnt + 5'h01;
              if (st_q.bitCnt + 5'h01 == cfg.bits) begin
                wordEnd = 1'b1;
              end
            end
            // drive edge only, never on the edge the slave samples
            if (!wordEnd && (st_q.half == cfg.phaInv)) begin
              st_d.mosi = msbOf(st_d.shift, cfg.bits);
            end
          end
          if (wordEnd) begin
            st_d.rxHold = maskTo(st_d.shift, cfg.bits);
            st_d.dlyCnt = dly;
            st_d.state  = SPIMSC_DELAY;
          end
        end
        SPIMSC_DELAY: begin
          st_d.sclk = cfg.pol;
          if (st_q.dlyCnt != 8'h00) begin
            st_d.dlyCnt = st_q.dlyCnt - 8'h01;
          end else if (!st_q.transfer_done_flag || txWrite) begin
            // a write in this cycle is pending work, not an end
            st_d.state = SPIMSC_IDLE;
          end else begin
            st_d.state = SPIMSC_IDLE;
            st_d.done  = 1'b1;
            st_d.csN   = SPIMSC_CS_IDLE;
          end
        end
        default: st_d.state = SPIMSC_IDLE;
      endcase
    end else begin
      st_d.state = SPIMSC_IDLE;
      st_d.csN   = SPIMSC_CS_IDLE;
      st_d.sclk  = cfg.pol;
      if (ssActive && st_q.ssPrev) begin
        // select falling: load pending data or keep last word
        st_d.bitCnt = 5'h00;
        if (!st_q.transfer_done_flag) begin
          st_d.shift   = st_q.txHold;
          st_d.transfer_done_flag = txWrite ? 1'b0 : 1'b1;
        end
        st_d.miso = msbOf(st_d.shift, cfg.bits);
      end else if (ssActive && (sclkS != st_q.sclkPrev)) begin
        sclkEdge = 1'b1;
        leadEdge = (sclkS != cfg.pol);
        if (leadEdge == cfg.phaInv) begin
          st_d.shift  = shl(st_q.shift, mosiS);
          st_d.bitCnt = st_q.bitCnt + 5'h01;
          if (st_q.bitCnt + 5'h01 == cfg.bits) begin
            wordEnd     = 1'b1;
            st_d.bitCnt = 5'h00;
            st_d.rxHold = maskTo(st_d.shift, cfg.bits);
          end
        end else begin
          st_d.miso = msbOf(st_q.shift, cfg.bits);
        end
      end
    end

    if (wordEnd) begin
      if (st_q.rxFull && !rxRead) begin
        st_d.ovr = 1'b1;
      end
      st_d.rxFull = 1'b1;
    end else if (rxRead) begin
      st_d.rxFull = 1'b0;
    end
    // a new overrun in the same cycle wins over the read
    if (statusRead && !(wordEnd && st_q.rxFull && !rxRead)) begin
      st_d.ovr = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q          <= '0;
      st_q.state    <= SPIMSC_IDLE;
      st_q.transfer_done_flag  <= 1'b1;
      st_q.done     <= 1'b1;
      st_q.csN      <= SPIMSC_CS_IDLE;
      st_q.shift    <= SPIMSC_SHIFT_RESET;
      st_q.sclkPrev <= 1'b0;
      st_q.ssPrev   <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign rxHoldingReg     = st_q.rxHold;
  assign txHoldingEmpty   = st_q.transfer_done_flag;
  assign dmaTxRequest     = st_q.transfer_done_flag;
  assign transferDoneFlag = st_q.done;
  assign rxHoldingFull    = st_q.rxFull;
  assign rxOverrunFlag    = st_q.ovr;
  assign sclkOut          = st_q.sclk;
  assign sclkOe           = cfg.isMaster;
  assign mosiOut          = st_q.mosi;
  assign mosiOe           = cfg.isMaster;
  // slave drives miso only while selected, so others can share it
  assign misoOut          = st_q.miso;
  assign misoOe           = ~cfg.isMaster & ~ssS & enable;
  assign periphSelectN    = st_q.csN;
  assign periphSelectOe   = {4{cfg.isMaster}};
endmodule
`default_nettype wire

// ### inc/spimsc_pkg.sv
/*
  spimsc_pkg: shared constants for the serial peripheral core.
  assumes a 100 MHz core clock; no register bus, all settings are ports.
*/
`default_nettype none
package spimsc_pkg;
  localparam int          SPIMSC_NUM_CS       = 4;
  localparam int          SPIMSC_MAX_BITS     = 16;
  localparam logic [4:0]  SPIMSC_MIN_BITS     = 5'h08;
  localparam logic [7:0]  SPIMSC_DIV_RESET    = 8'h01;
  localparam logic [15:0] SPIMSC_SHIFT_RESET  = 16'h0000;
  localparam logic [3:0]  SPIMSC_CS_IDLE      = 4'hf;
  localparam int          SPIMSC_CFG_W        = 26;
  // per-select configuration word layout
  localparam int          SPIMSC_CFG_POL      = 0;
  localparam int          SPIMSC_CFG_PHA_INV  = 1;
  localparam int          SPIMSC_CFG_BITS_LO  = 2;
  localparam int          SPIMSC_CFG_DIV_LO   = 10;
  localparam int          SPIMSC_CFG_DLY_LO   = 18;
endpackage
`default_nettype wire

// ### inc/spimsc_cfg_if.sv
/*
  spimsc_cfg_if: active settings handed from the top to the shifter.
  assumes one clock domain; the top drives, the shifter reads.
*/
`timescale 1ns/10ps
`default_nettype none
interface spimsc_cfg_if;
  logic       pol;
  logic       phaInv;
  logic [4:0] bits;
  logic       isMaster;
  modport src (output pol, output phaInv, output bits, output isMaster);
  modport dst (input pol, input phaInv, input bits, input isMaster);
endinterface
`default_nettype wire

// ### rtl/spimsc_sync.sv
/*
  spimsc_sync: two-flop synchroniser for pin inputs.
  assumes asynchronous pin levels; output is in the clk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module spimsc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] async,
  output logic      [W-1:0] synced
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } spimsc_sync_t;
  spimsc_sync_t st_q;
  spimsc_sync_t st_d;
  always_comb begin
    st_d    = st_q;
    st_d.s1 = async;
    st_d.s2 = st_q.s1;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign synced = st_q.s2;
endmodule
`default_nettype wire

// ### testbench/spimsc_core_properties.sv
/*
  spimsc_core_properties: pin and flag relations of the serial core.
  assumes it is bound to spimsc_core and sees only that module's ports.
*/
`timescale 1ns/10ps
`default_nettype none
module spimsc_core_properties (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       masterSelectBit,
  input wire logic       txWrite,
  input wire logic       rxRead,
  input wire logic       statusRead,
  input wire logic       txHoldingEmpty,
  input wire logic       transferDoneFlag,
  input wire logic       rxHoldingFull,
  input wire logic       rxOverrunFlag,
  input wire logic       dmaTxRequest,
  input wire logic       sclkOe,
  input wire logic       mosiOe,
  input wire logic       misoOe,
  input wire logic [3:0] periphSelectN,
  input wire logic [3:0] periphSelectOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_mpins; (sclkOe & mosiOe) == masterSelectBit && &periphSelectOe == masterSelectBit;
  endproperty
  a_mpins: assert property (p_mpins) else $error("master pin enables wrong");
  property p_spins; misoOe |-> !masterSelectBit && periphSelectOe == 4'h0; endproperty
  a_spins: assert property (p_spins) else $error("slave pin enables wrong");
  property p_onesel; $onehot0(~periphSelectN); endproperty
  a_onesel: assert property (p_onesel) else $error("two selects low");
  property p_start; txWrite && masterSelectBit && transferDoneFlag |-> ##[1:3] periphSelectN != 4'hf;
  endproperty
  a_start: assert property (p_start) else $error("write did not start transfer");
  property p_txclr; txWrite |=> !txHoldingEmpty; endproperty
  a_txclr: assert property (p_txclr) else $error("tx empty not cleared");
  property p_dma; dmaTxRequest == txHoldingEmpty; endproperty
  a_dma: assert property (p_dma) else $error("dma request differs");
  property p_done; transferDoneFlag |-> txHoldingEmpty && &periphSelectN; endproperty
  a_done: assert property (p_done) else $error("done with work pending");
  property p_rxclr; rxRead |=> !rxHoldingFull; endproperty
  a_rxclr: assert property (p_rxclr) else $error("rx full not cleared");
  property p_ovrset; $rose(rxOverrunFlag) |-> $past(rxHoldingFull) && rxHoldingFull; endproperty
  a_ovrset: assert property (p_ovrset) else $error("overrun without full");
  // in master mode idle selects rule out a store racing the read; in slave mode the selects stay idle while words are stored
  property p_ovrclr; statusRead && &periphSelectN |=> !rxOverrunFlag; endproperty
  a_ovrclr: assert property (p_ovrclr) else $error("overrun not cleared");
endmodule
bind spimsc_core spimsc_core_properties i_spimsc_core_properties (
  .clk              (clk),
  .reset            (reset),
  .masterSelectBit  (masterSelectBit),
  .txWrite          (txWrite),
  .rxRead           (rxRead),
  .statusRead       (statusRead),
  .txHoldingEmpty   (txHoldingEmpty),
  .transferDoneFlag (transferDoneFlag),
  .rxHoldingFull    (rxHoldingFull),
  .rxOverrunFlag    (rxOverrunFlag),
  .dmaTxRequest     (dmaTxRequest),
  .sclkOe           (sclkOe),
  .mosiOe           (mosiOe),
  .misoOe           (misoOe),
  .periphSelectN    (periphSelectN),
  .periphSelectOe   (periphSelectOe)
);
`default_nettype wire

// ### testbench/spimsc_slave_model.sv
/*
  spimsc_slave_model: behavioural serial slave on one select line.
  assumes the bench hands it the mode and word length in use.
*/
`timescale 1ns/10ps
`default_nettype none
module spimsc_slave_model (
  input  wire logic        sclk,
  input  wire logic        mosi,
  input  wire logic        csN,
  input  wire logic        pol,
  input  wire logic        phaInv,
  input  wire logic [4:0]  bits,
  input  wire logic [15:0] txWord,
  output logic             miso,
  output logic [15:0]      rxWord
);
  int bitPos = 15;
  bit first  = 1;
  // released line shows the inverse so a stale level cannot pass
  assign miso = csN ? ~txWord[bitPos] : txWord[bitPos];
  always @(negedge csN) begin
    bitPos = bits - 1;
    first  = 1;
  end
  // wraps to the msb so chained words need no reselect
  always @(sclk) if (!csN) begin
    if (sclk == (pol ^ phaInv)) begin
      rxWord = {rxWord[14:0], mosi};
      first  = 0;
    end else if (!first) bitPos = (bitPos == 0) ? bits - 1 : bitPos - 1;
  end
endmodule
`default_nettype wire

// ### testbench/spimsc_core_tb.sv
/*
  spimsc_core_tb: self-checking bench for the serial core, master and slave.
  assumes spimsc_slave_model on the selected line and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
module spimsc_core_tb;
  import spimsc_pkg::*;
  logic        clk = 0, reset = 1, msel = 1, txWrite = 0, rxRead = 0, statusRead = 0;
  logic        tbSclk = 0, tbMosi = 0, tbSs = 1, mPol = 0, mPha = 1, mMiso;
  logic        transfer_done_flag, done, rxFull, ovr, dma, sclkOut, sclkOe, mosiOut, mosiOe, misoOut, misoOe;
  logic [1:0]  psel = 0;
  logic [4:0]  mBits = 8;
  logic [15:0] txData = 0, mTx = 0, mRx, rxHold;
  logic [103:0] cfg = 0;
  logic [3:0]  csN, csOe;
  int          err_total = 0, tests_run = 0, cyc = 0, edges = 0;
  time         lastT = 0, gap = 0;
  wire         sclkPin = sclkOe ? sclkOut : tbSclk;
  wire         mosiPin = mosiOe ? mosiOut : tbMosi;
  wire         misoPin = misoOe ? misoOut : mMiso;
  spimsc_core i_spimsc_core (.clk(clk), .reset(reset), .enable(1'b1), .masterSelectBit(msel),
    .periphSelectField(psel), .selectCfg(cfg), .txWrite(txWrite), .txData(txData),
    .rxRead(rxRead), .statusRead(statusRead), .rxHoldingReg(rxHold), .txHoldingEmpty(transfer_done_flag),
    .transferDoneFlag(done), .rxHoldingFull(rxFull), .rxOverrunFlag(ovr), .dmaTxRequest(dma),
    .sclkOut(sclkOut), .sclkOe(sclkOe), .sclkIn(sclkPin), .mosiOut(mosiOut), .mosiOe(mosiOe),
    .mosiIn(mosiPin), .misoOut(misoOut), .misoOe(misoOe), .misoIn(misoPin),
    .periphSelectN(csN), .periphSelectOe(csOe), .select0OrSlaveSelectN(tbSs));
  spimsc_slave_model i_spimsc_slave_model (.sclk(sclkPin), .mosi(mosiPin),
    .csN(msel ? csN[psel] : 1'b1), .pol(mPol), .phaInv(mPha), .bits(mBits), .txWord(mTx),
    .miso(mMiso), .rxWord(mRx));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      complete_run();
    end
  end
  // leading edges only, so an idle level change is never counted
  always @(sclkOut) if (sclkOut !== mPol) begin
    edges++;
    gap   = $time - lastT;
    lastT = $time;
  end
  task automatic complete_run();
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_flag(string n, logic e, logic g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic chk_word(string n, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    tick(1);
    s = 0;
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int i;
    i = 0;
    while (s !== v && i < 3000) begin
      tick(1);
      i++;
    end
    chk_flag("wait", v, s);
  endtask
  function automatic logic [25:0] cfgw(logic p, logic h, logic [7:0] b, d, y);
    return {y, d, b, h, p};
  endfunction
  task automatic t_reset();
    chk_flag("transfer_done_flag", 1, transfer_done_flag);
    chk_flag("done", 1, done);
    chk_flag("rxFull", 0, rxFull);
    chk_word("select", 16'h000f, {12'h000, csN});
  endtask
  task automatic t_modes();
    logic [4:0]  bt [4] = '{5'h08, 5'h10, 5'h0c, 5'h08};
    logic [15:0] mask;
    for (int m = 0; m < 4; m++) begin
      mPol  = m[1];
      mPha  = ~m[0];
      mBits = bt[m];
      psel  = 2'(m);
      mask  = 16'hffff >> (16 - bt[m]);
      // wrong settings elsewhere prove the addressed word is used
      cfg = {4{cfgw(~mPol, ~mPha, 8'h10, 8'h01, 8'h00)}};
      cfg[26*m +: 26] = cfgw(mPol, mPha, 8'(bt[m]), 8'(2*m+4), 8'h00);
      tick(4);
      edges  = 0;
      mTx    = 16'h5ac3 + 16'(m);
      txData = 16'hc3a5 >> m;
      pulse(txWrite);
      tick(3);
      chk_word("select", {12'h000, ~(4'h1 << m)}, {12'h000, csN});
      wait_for(done, 1);
      chk_word("rxHold", mTx & mask, rxHold);
      chk_word("slaveRx", txData & mask, mRx & mask);
      chk_word("edges", 16'(bt[m]), 16'(edges));
      chk_word("period", 16'(4*m+8), 16'(gap / 10));
      chk_flag("idle", mPol, sclkOut);
      pulse(rxRead);
      chk_flag("rxFull", 0, rxFull);
    end
  endtask
  task automatic t_chain();
    mPol = 0;
    mPha = 1;
    mBits = 8;
    psel = 0;
    cfg = {4{cfgw(1'b0, 1'b1, 8'h08, 8'h04, 8'h06)}};
    mTx = 16'h00a6;
    tick(4);
    txData = 16'h0071;
    pulse(txWrite);
    tick(2);
    chk_flag("transfer_done_flag", 1, transfer_done_flag);
    chk_flag("dma", 1, dma);
    txData = 16'h008e;
    pulse(txWrite);
    tick(1);
    chk_flag("transfer_done_flag", 0, transfer_done_flag);
    chk_flag("dma", 0, dma);
    wait_for(rxFull, 1);
    mTx = 16'h0039;
    chk_word("first", 16'h00a6, rxHold);
    chk_flag("done", 0, done);
    wait_for(transfer_done_flag, 1);
    wait_for(ovr, 1);
    chk_flag("rxFull", 1, rxFull);
    chk_word("overwrite", 16'h0039, rxHold);
    chk_word("slaveRx", 16'h008e, mRx & 16'h00ff);
    chk_flag("done", 0, done);
    wait_for(done, 1);
    pulse(statusRead);
    chk_flag("ovr", 0, ovr);
    chk_flag("rxFull", 1, rxFull);
    pulse(rxRead);
    chk_flag("rxFull", 0, rxFull);
  endtask
  task automatic t_slave();
    logic [7:0] b = 8'hb4;
    logic [7:0] got;
    msel = 0;
    psel = 1;
    cfg = {{3{cfgw(1'b1, 1'b0, 8'h10, 8'h04, 8'h00)}}, cfgw(1'b0, 1'b1, 8'h08, 8'h04, 8'h00)};
    tick(4);
    chk_flag("slaveOe", 0, sclkOe | mosiOe | (|csOe));
    txData = 16'h0069;
    pulse(txWrite);
    tbSs = 0;
    tick(8);
    chk_flag("misoOe", 1, misoOe);
    chk_flag("transfer_done_flag", 1, transfer_done_flag);
    for (int i = 7; i >= 0; i--) begin
      tbMosi = b[i];
      tick(8);
      got[i] = misoPin;
      tbSclk = 1;
      tick(8);
      tbSclk = 0;
    end
    tick(8);
    tbSs = 1;
    tbMosi = ~tbMosi;
    wait_for(rxFull, 1);
    chk_word("slaveRx", 16'h00b4, rxHold);
    chk_word("slaveTx", 16'h0069, {8'h00, got});
  endtask
  initial begin
    tick(20);
    reset = 0;
    tick(1);
    t_reset();
    t_modes();
    t_chain();
    t_slave();
    complete_run();
  end
endmodule
`default_nettype wire
